// File: hw/hpss_defs.svh
// Constants for the host port status synchroniser: register selects, timing counts.
// Assumes inclusion from the package, from design modules and from the bench.
`ifndef HPSS_DEFS_SVH
`define HPSS_DEFS_SVH

// ****************************************************************
// Host register selects (three address lines)
// ****************************************************************
`define HPSS_SEL_CTRL 3'h0
`define HPSS_SEL_CMD 3'h1
`define HPSS_SEL_STAT 3'h2
`define HPSS_SEL_HIGH 3'h5
`define HPSS_SEL_MID 3'h6
`define HPSS_SEL_LOW 3'h7

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define HPSS_VEC_W 5
`define HPSS_VEC_RESET 5'h00
`define HPSS_STAT_CMD 7
`define HPSS_STAT_DMA 6
`define HPSS_STAT_FB 4
`define HPSS_STAT_FA 3
`define HPSS_STAT_TRANSMITTER_READY_FLAG 2
`define HPSS_STAT_TXE 1
`define HPSS_STAT_RXF 0

// ****************************************************************
// Timing: extra cycles before the request line returns
// ****************************************************************
`define HPSS_CLK_PERIOD_NS 50
`define HPSS_REQ_GAP_NS 50
`define HPSS_REQ_GAP_CYC ((`HPSS_REQ_GAP_NS + `HPSS_CLK_PERIOD_NS - 1) / `HPSS_CLK_PERIOD_NS)

`endif

// File: hw/hpss_pkg.sv
// Types of the host port status synchroniser.
// Assumes hpss_defs.svh on the include path.
`include "hpss_defs.svh"
package hpss_pkg;
    typedef logic [23:0] hpss_word_t;
    typedef logic [7:0] hpss_byte_t;
    typedef enum logic [1:0]
    {
        HPSS_IDLE = 2'b00,
        HPSS_BUSY = 2'b01,
        HPSS_GAP = 2'b10
    } hpss_strobe_e;
endpackage

// File: hw/hpss_sync2.sv
// Two-flop level synchroniser, one instance per host-side flag or mode bit (vector and word bits have none).
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module hpss_sync2
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_reg;
    logic stage2_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end
    assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// File: hw/hpss_host_port.sv
// Byte-wide host port: host strobe side, status flags, word assembly.
// Assumes host pins are synchronous to core_clk (pre-synchronised upstream),
// and that the device core reads the synchronised status outputs.
`timescale 1ns/100ps
`default_nettype none
`include "hpss_defs.svh"
module hpss_host_port
    import hpss_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Host pins (enable active low)
    input wire logic hostEnableStrobe_n,
    input wire logic hostReadWrite,
    input wire logic [2:0] hostSelect,
    input wire logic [7:0] hostDataIn,
    output logic [7:0] hostDataOut,
    output logic hostDataOe_n,
    output logic hostRequestLine_n,
    // Host-side controls
    input wire logic dmaMode,
    // Device core side
    input wire logic [23:0] txWordIn,
    input wire logic txWordLoad,
    input wire logic rxWordTake,
    input wire logic devToHostFlagA,
    input wire logic devToHostFlagB,
    output logic [23:0] deviceSideReceiveWord,
    output logic deviceTransmitEmptyFlag,
    output logic deviceReceiveFullFlag,
    output logic commandPendingFlag,
    output logic [4:0] hostVectorBits,
    output logic hostToDevFlagASync,
    output logic hostToDevFlagBSync,
    output logic hostToDevPairValid,
    output logic [1:0] hostToDevPair,
    output logic dmaModeSync
);
    // ****************************************************************
    // Strobe edge tracking
    // ****************************************************************
    hpss_strobe_e strobeState_reg;
    hpss_strobe_e strobeState_next;
    logic accessStart;
    logic accessEnd;
    logic isWrite;
    logic lowByteAccess;

    // One update per strobe
    // Actions fire only on the assert edge and a full release
    assign accessStart = (strobeState_reg == HPSS_IDLE) && !hostEnableStrobe_n;
    assign accessEnd = (strobeState_reg == HPSS_BUSY) && hostEnableStrobe_n;
    assign isWrite = !hostReadWrite;
    assign lowByteAccess = accessStart && (hostSelect == `HPSS_SEL_LOW);

    // Strobe state decode
    always_comb
    begin
        case (strobeState_reg)
            HPSS_IDLE: strobeState_next = hostEnableStrobe_n ? HPSS_IDLE : HPSS_BUSY;
            HPSS_BUSY: strobeState_next = hostEnableStrobe_n ? HPSS_GAP : HPSS_BUSY;
            HPSS_GAP: strobeState_next = HPSS_IDLE;
            default: strobeState_next = HPSS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            strobeState_reg <= HPSS_IDLE;
        else
            strobeState_reg <= strobeState_next;
    end

    // ****************************************************************
    // Byte registers and flags
    // ****************************************************************
    logic [7:0] txHigh_reg, txMid_reg;
    logic [23:0] rxByteWord_reg;
    logic [23:0] hrxWord_reg;
    logic transmitEmptyFlag_reg;
    logic receiveFullFlag_reg;
    logic hrxFull_reg;
    logic hostCmdBit_reg;
    logic [4:0] hostVec_reg;
    logic flagA_reg, flagB_reg;
    logic [7:0] dataOut_reg;
    logic lowWrite;
    logic lowRead;
    logic hostCmdTaken;

    assign lowWrite = lowByteAccess && isWrite && transmitEmptyFlag_reg;
    assign lowRead = lowByteAccess && !isWrite;
    assign hostCmdTaken = hostCmdBit_reg && !dmaMode;

    // Word assembly from three host bytes
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            txHigh_reg <= 8'h00;
            txMid_reg <= 8'h00;
            hrxWord_reg <= 24'h00_0000;
            hrxFull_reg <= 1'b0;
        end
        else
        begin
            if (accessStart && isWrite && hostSelect == `HPSS_SEL_HIGH)
                txHigh_reg <= hostDataIn;
            if (accessStart && isWrite && hostSelect == `HPSS_SEL_MID)
                txMid_reg <= hostDataIn;
            if (lowWrite)
            begin
                hrxWord_reg <= {txHigh_reg, txMid_reg, hostDataIn};
                hrxFull_reg <= 1'b1;
            end
            else if (rxWordTake)
                hrxFull_reg <= 1'b0;
        end
    end

    // Empty and full flags; clear wins over set for empty, set wins over clear for full
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            transmitEmptyFlag_reg <= 1'b1;
            receiveFullFlag_reg <= 1'b0;
            rxByteWord_reg <= 24'h00_0000;
        end
        else
        begin
            if (lowWrite)
                transmitEmptyFlag_reg <= 1'b0;
            else if (!hrxFull_reg)
                transmitEmptyFlag_reg <= 1'b1;
            if (txWordLoad)
            begin
                receiveFullFlag_reg <= 1'b1;
                rxByteWord_reg <= txWordIn;
            end
            else if (lowRead)
                receiveFullFlag_reg <= 1'b0;
        end
    end

    // Command, vector and host flags written over the control selects
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            hostCmdBit_reg <= 1'b0;
            hostVec_reg <= `HPSS_VEC_RESET;
            flagA_reg <= 1'b0;
            flagB_reg <= 1'b0;
        end
        else if (accessStart && isWrite && hostSelect == `HPSS_SEL_CMD)
        begin
            // Clearing the command cancels a pending request
            hostCmdBit_reg <= hostDataIn[7];
            // Vector only written while no command pending
            if (!hostCmdBit_reg)
                hostVec_reg <= hostDataIn[4:0];
        end
        else if (accessStart && isWrite && hostSelect == `HPSS_SEL_CTRL)
        begin
            flagA_reg <= hostDataIn[3];
            flagB_reg <= hostDataIn[4];
        end
    end

    // ****************************************************************
    // Host read data and request line
    // ****************************************************************
    logic [7:0] statusByte;
    logic [7:0] readMux;
    logic [3:0] reqGap_reg;
    logic reqHold_reg;
    logic reqWant;

    assign statusByte = {hostCmdBit_reg, dmaMode, 1'b0, devToHostFlagB, devToHostFlagA,
                         transmitEmptyFlag_reg && !hrxFull_reg, transmitEmptyFlag_reg,
                         receiveFullFlag_reg};
    assign readMux = (hostSelect == `HPSS_SEL_STAT) ? statusByte :
                     (hostSelect == `HPSS_SEL_HIGH) ? rxByteWord_reg[23:16] :
                     (hostSelect == `HPSS_SEL_MID) ? rxByteWord_reg[15:8] :
                     (hostSelect == `HPSS_SEL_LOW) ? rxByteWord_reg[7:0] : 8'h00;

    // Read byte latched once at strobe start, stable while held
    always_ff @(posedge core_clk)
    begin
        if (reset)
            dataOut_reg <= 8'h00;
        else if (accessStart && !isWrite)
            dataOut_reg <= readMux;
    end
    assign hostDataOut = dataOut_reg;
    assign hostDataOe_n = !(strobeState_reg == HPSS_BUSY && !isWrite);

    // Request drops on low byte, returns after release plus gap
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            reqHold_reg <= 1'b0;
            reqGap_reg <= 4'h0;
        end
        else if (lowByteAccess)
            reqHold_reg <= 1'b1;
        else if (accessEnd && reqHold_reg)
            reqGap_reg <= 4'(`HPSS_REQ_GAP_CYC);
        else if (reqGap_reg != 4'h0)
        begin
            reqGap_reg <= reqGap_reg - 4'h1;
            if (reqGap_reg == 4'h1)
                reqHold_reg <= 1'b0;
        end
    end
    assign reqWant = receiveFullFlag_reg || transmitEmptyFlag_reg;
    assign hostRequestLine_n = !(reqWant && !reqHold_reg);

    // ****************************************************************
    // Crossing of host-side bits into the core
    // ****************************************************************
    logic [4:0] syncIn;
    logic [4:0] syncOut;
    logic [1:0] pairPrev_reg;

    // Each host-side flag or mode bit gets its own synchroniser; hostVec_reg and hrxWord_reg go across unsynchronised
    assign syncIn = {dmaMode, flagB_reg, flagA_reg, hostCmdTaken, hrxFull_reg};
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            hpss_sync2 u_sync
            (
                .core_clk(core_clk),
                .reset(reset),
                .asyncIn(syncIn[gi]),
                .syncOut(syncOut[gi])
            );
        end
    endgenerate
    assign deviceReceiveFullFlag = syncOut[0];
    assign deviceTransmitEmptyFlag = !syncOut[0];
    assign commandPendingFlag = syncOut[1];
    assign hostToDevFlagASync = syncOut[2];
    assign hostToDevFlagBSync = syncOut[3];
    assign dmaModeSync = syncOut[4];
    assign deviceSideReceiveWord = hrxWord_reg;
    assign hostVectorBits = hostVec_reg;

    // Pair accepted only when two samples agree
    always_ff @(posedge core_clk)
    begin
        if (reset)
            pairPrev_reg <= 2'b00;
        else
            pairPrev_reg <= syncOut[3:2];
    end
    assign hostToDevPairValid = (pairPrev_reg == syncOut[3:2]);
    assign hostToDevPair = pairPrev_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // devToHost pair is passed through raw; no coherence claimed
    one_update_a: assert property (@(posedge core_clk) disable iff (reset)
        accessStart |=> !accessStart [*2])
        else $error("strobe start fired twice");
    req_drop_a: assert property (@(posedge core_clk) disable iff (reset)
        lowByteAccess |=> hostRequestLine_n)
        else $error("request not dropped");
    word_load_a: assert property (@(posedge core_clk) disable iff (reset)
        lowWrite |=> hrxFull_reg && !transmitEmptyFlag_reg)
        else $error("low byte write not completing word");
    rx_clear_a: assert property (@(posedge core_clk) disable iff (reset)
        (lowRead && !txWordLoad) |=> !receiveFullFlag_reg)
        else $error("receive full not cleared");
    sync_lat_a: assert property (@(posedge core_clk) disable iff (reset)
        $rose(hrxFull_reg) |-> ##2 deviceReceiveFullFlag)
        else $error("sync latency wrong");
    pair_ok_a: assert property (@(posedge core_clk) disable iff (reset)
        hostToDevPairValid |-> (hostToDevPair == {hostToDevFlagBSync, hostToDevFlagASync}) &&
            (hostToDevPair == $past({hostToDevFlagBSync, hostToDevFlagASync})))
        else $error("pair accepted without agreement");
    read_stable_a: assert property (@(posedge core_clk) disable iff (reset)
        (strobeState_reg == HPSS_BUSY) |=> (strobeState_reg != HPSS_BUSY) || $stable(hostDataOut))
        else $error("read data moved during strobe");
    vec_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        hostCmdBit_reg |=> $stable(hostVec_reg))
        else $error("vector changed while command pending");
    req_back_a: assert property (@(posedge core_clk) disable iff (reset)
        (accessEnd && reqHold_reg) |-> ##1 reqHold_reg ##1 !reqHold_reg)
        else $error("request gap wrong");
    word_c: cover property (@(posedge core_clk) lowWrite ##[1:20] rxWordTake);
    read_c: cover property (@(posedge core_clk) txWordLoad ##[1:20] lowRead);
    cmd_c: cover property (@(posedge core_clk) commandPendingFlag ##[1:20] !commandPendingFlag);
endmodule
`default_nettype wire

// File: bench/hpss_host_model.sv
// Host processor model: byte accesses on the host pins of the port.
// Assumes a single core_clk; pins change only at its falling edge.
`timescale 1ns/100ps
`default_nettype none
module hpss_host_model
    import hpss_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Host pins
    output var logic hostEnableStrobe_n,
    output var logic hostReadWrite,
    output var logic [2:0] hostSelect,
    output var logic [7:0] hostDataIn,
    input wire logic [7:0] hostDataOut,
    input wire logic hostDataOe_n
);
    // ****************************************************************
    // Idle pins
    // ****************************************************************
    initial
    begin
        hostEnableStrobe_n = 1'b1;
        hostReadWrite = 1'b1;
        hostSelect = 3'h0;
        hostDataIn = 8'h5_A;
    end

    // One access; a released data line shows the inverse of its last value
    // long strobe allowed
    task automatic access(input logic rd, input logic [2:0] sel, input hpss_byte_t wd,
        input int hold, output hpss_byte_t rdat);
        @(negedge core_clk);
        hostReadWrite = rd;
        hostSelect = sel;
        hostDataIn = wd;
        hostEnableStrobe_n = 1'b0;
        repeat (hold) @(posedge core_clk);
        #1;
        rdat = (hostDataOe_n === 1'b0) ? hostDataOut : ~hostDataOut;
        @(negedge core_clk);
        hostEnableStrobe_n = 1'b1;
        hostDataIn = ~wd;
        // Two full idle cycles before the next strobe
        repeat (2) @(negedge core_clk);
    endtask

    // caller writes transmit bytes only when empty, bar one deliberately refused low write
    task automatic hwrite(input logic [2:0] sel, input hpss_byte_t wd, input int hold);
        hpss_byte_t dummy;
        access(1'b0, sel, wd, hold, dummy);
    endtask

    // caller polls full flag before receive bytes
    task automatic hread2(input logic [2:0] sel, output hpss_byte_t d, output logic agree);
        hpss_byte_t d2;
        access(1'b1, sel, 8'h0_0, 2, d);
        access(1'b1, sel, 8'h0_0, 2, d2);
        agree = (d === d2);
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the host port: random words and flags, corner cases.
// Assumes hpss_pkg compiled first and the host model beside it.
`timescale 1ns/100ps
`default_nettype none
`include "hpss_defs.svh"
module tb;
    import hpss_pkg::*;
    logic core_clk, reset, hostEnableStrobe_n, hostReadWrite, hostDataOe_n, hostRequestLine_n;
    logic [2:0] hostSelect;
    logic [7:0] hostDataIn, hostDataOut;
    logic dmaMode, txWordLoad, rxWordTake, devToHostFlagA, devToHostFlagB;
    logic [23:0] txWordIn, deviceSideReceiveWord;
    logic deviceTransmitEmptyFlag, deviceReceiveFullFlag, commandPendingFlag, dmaModeSync;
    logic hostToDevFlagASync, hostToDevFlagBSync, hostToDevPairValid;
    logic [4:0] hostVectorBits, v;
    logic [1:0] hostToDevPair, c;
    logic ag;
    hpss_byte_t d, h, m, l;
    hpss_word_t w;
    int n_fail, n_checks, k, i, seed;

    // ****************************************************************
    // Design, host model, clock
    // ****************************************************************
    hpss_host_port i_hpss_host_port (.core_clk(core_clk), .reset(reset),
        .hostEnableStrobe_n(hostEnableStrobe_n), .hostReadWrite(hostReadWrite),
        .hostSelect(hostSelect), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe_n(hostDataOe_n), .hostRequestLine_n(hostRequestLine_n), .dmaMode(dmaMode),
        .txWordIn(txWordIn), .txWordLoad(txWordLoad), .rxWordTake(rxWordTake),
        .devToHostFlagA(devToHostFlagA), .devToHostFlagB(devToHostFlagB),
        .deviceSideReceiveWord(deviceSideReceiveWord),
        .deviceTransmitEmptyFlag(deviceTransmitEmptyFlag),
        .deviceReceiveFullFlag(deviceReceiveFullFlag), .commandPendingFlag(commandPendingFlag),
        .hostVectorBits(hostVectorBits), .hostToDevFlagASync(hostToDevFlagASync),
        .hostToDevFlagBSync(hostToDevFlagBSync), .hostToDevPairValid(hostToDevPairValid),
        .hostToDevPair(hostToDevPair), .dmaModeSync(dmaModeSync));
    hpss_host_model i_hpss_host_model (.core_clk(core_clk),
        .hostEnableStrobe_n(hostEnableStrobe_n), .hostReadWrite(hostReadWrite),
        .hostSelect(hostSelect), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe_n(hostDataOe_n));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Expected status byte; ready bit masked off since its equation is not fixed
    function automatic hpss_byte_t statExp(logic dma, logic fb, logic fa, logic te, logic rf);
        return {1'b0, dma, 1'b0, fb, fa, 1'b0, te, rf};
    endfunction

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the sequence needs under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        close_out();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        {reset, dmaMode, txWordLoad, rxWordTake, devToHostFlagA, devToHostFlagB} = 6'b10_0000;
        txWordIn = 24'h00_0000;
        n_fail = 0;
        n_checks = 0;
        seed = $urandom(93);
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) reset = 1'b0;
        @(posedge core_clk) #1;
        chk("request after reset", 1'b0, hostRequestLine_n);
        chk("oe idle", 1'b1, hostDataOe_n);
        i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
        chk("reset status", statExp(0, 0, 0, 1, 0), d & 8'hF_B);
        // Host to device words; all ones and all zeros as corners
        for (i = 0; i < 5; i++)
        begin
            w = (i == 0) ? 24'hFF_FFFF : (i == 1) ? 24'h00_0000 : 24'($urandom);
            i_hpss_host_model.hwrite(`HPSS_SEL_HIGH, w[23:16], 1);
            i_hpss_host_model.hwrite(`HPSS_SEL_MID, w[15:8], 1);
            i_hpss_host_model.hwrite(`HPSS_SEL_LOW, w[7:0], 1 + $urandom_range(3));
            chk("request after low write", 1'b1, hostRequestLine_n);
            for (k = 0; k < 10 && deviceReceiveFullFlag !== 1'b1; k++) @(posedge core_clk) #1;
            chk("device full", 1'b1, deviceReceiveFullFlag);
            chk("device word", w, deviceSideReceiveWord);
            chk("device empty", 1'b0, deviceTransmitEmptyFlag);
            if (i == 0)
            begin
                i_hpss_host_model.hwrite(`HPSS_SEL_LOW, 8'h3_C, 1);
                chk("refused low write", w, deviceSideReceiveWord);
            end
            @(negedge core_clk) rxWordTake = 1'b1;
            @(negedge core_clk) rxWordTake = 1'b0;
            for (k = 0; k < 10 && hostRequestLine_n !== 1'b0; k++) @(posedge core_clk) #1;
            chk("request returns", 1'b0, hostRequestLine_n);
        end
        // Device to host words, host polls the full flag first
        for (i = 0; i < 3; i++)
        begin
            w = 24'($urandom);
            @(negedge core_clk);
            txWordIn = w;
            txWordLoad = 1'b1;
            @(negedge core_clk) txWordLoad = 1'b0;
            d = 8'h0_0;
            for (k = 0; k < 8 && d[0] !== 1'b1; k++)
                i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
            chk("host full", 1'b1, d[0]);
            i_hpss_host_model.hread2(`HPSS_SEL_HIGH, h, ag);
            i_hpss_host_model.hread2(`HPSS_SEL_MID, m, ag);
            i_hpss_host_model.access(1'b1, `HPSS_SEL_LOW, 8'h0_0, 2, l);
            chk("host word", w, {h, m, l});
            i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
            chk("full cleared", 1'b0, d[0]);
        end
        // Every flag pair code host to device, random codes device to host
        for (i = 0; i < 4; i++)
        begin
            c = 2'(i);
            i_hpss_host_model.hwrite(`HPSS_SEL_CTRL, {3'b000, c, 3'b000}, 2);
            for (k = 0; k < 10 && !(hostToDevPairValid === 1'b1 && hostToDevPair === c); k++)
                @(posedge core_clk) #1;
            chk("pair", {1'b1, c}, {hostToDevPairValid, hostToDevPair});
            chk("synced flags", c, {hostToDevFlagBSync, hostToDevFlagASync});
            @(negedge core_clk) {devToHostFlagB, devToHostFlagA} = 2'($urandom);
            i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
            chk("double read", 1'b1, ag);
            chk("dev flags", statExp(0, devToHostFlagB, devToHostFlagA, 1, 0), d & 8'hF_B);
        end
        // Command, vector lock while pending, cancel
        v = 5'($urandom);
        i_hpss_host_model.hwrite(`HPSS_SEL_CMD, {3'b100, v}, 2);
        for (k = 0; k < 10 && commandPendingFlag !== 1'b1; k++) @(posedge core_clk) #1;
        chk("cmd pending", 1'b1, commandPendingFlag);
        chk("vector", v, hostVectorBits);
        i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
        chk("cmd status", 1'b1, d[7]);
        i_hpss_host_model.hwrite(`HPSS_SEL_CMD, {3'b100, ~v}, 2);
        chk("vector locked", v, hostVectorBits);
        i_hpss_host_model.hwrite(`HPSS_SEL_CMD, {3'b000, v}, 2);
        for (k = 0; k < 10 && commandPendingFlag !== 1'b0; k++) @(posedge core_clk) #1;
        chk("cmd cancelled", 1'b0, commandPendingFlag);
        i_hpss_host_model.hwrite(`HPSS_SEL_CMD, {3'b000, ~v}, 2);
        chk("vector free", 5'(~v), hostVectorBits);
        // Reset in mid-run: vector back to rest, request asserted again
        @(negedge core_clk) reset = 1'b1;
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        @(posedge core_clk) #1;
        chk("vector reset", 5'h00, hostVectorBits);
        chk("request after mid reset", 1'b0, hostRequestLine_n);
        chk("empty after mid reset", 1'b1, deviceTransmitEmptyFlag);
        // Host side mode bit
        @(negedge core_clk) dmaMode = 1'b1;
        for (k = 0; k < 10 && dmaModeSync !== 1'b1; k++) @(posedge core_clk) #1;
        chk("dma synced", 1'b1, dmaModeSync);
        i_hpss_host_model.hread2(`HPSS_SEL_STAT, d, ag);
        chk("dma status", 1'b1, d[6]);
        close_out();
    end
endmodule
`default_nettype wire
